// ===== hw/ufp_host.sv
/*
 * Host-side controller driving the FIFO port of a USB controller: selects
 * pipes, writes packet data, commits buffers, reads odd-length data and
 * fetches the function address. Assumes the device answers reads one cycle
 * after the strobe and that software polls the busy flag.
 */
// Our own choices: the address map and strobed register access.
// Behaviour
// [R01] Software sets buffer-valid after finishing a transmit buffer write.
// [R02] Device moves a committed transmit buffer to the serial engine.
// [R03] Short packet: write the data first, then set buffer-valid.
// [R04] Zero-length packet: set buffer-valid before writing any data.
// [R05] Continuous mode: commit after whole max-packet multiples below buffer.
// [R06] Non-continuous mode: device commits itself after a full packet.
// [R07] Buffer-valid with buffer-clear together discards data, sends empty packet.
// [R08] Buffer-valid written only while port-ready reads one.
// [R09] Never set buffer-valid while the current pipe receives.
// [R10] Function mode: read-only seven-bit address set by the host.
// [R11] Host mode: address register unused; use target device select.
// [R12] Address clears to zero on power-on or bus reset.
// [R13] Upper address bits read zero; software writes zero there.
// [R14] Selecting a pipe with rewind restarts pointer at first byte.
// [R15] Selecting without rewind continues from the previous pointer.
// [R16] After selecting a pipe, wait for port-ready before FIFO access.
// [R17] Partial reads still use full width; surplus bits are discarded.
// [R18] Width codes: 00 byte, 01 half-word, 10 word; 11 forbidden.
// [R19] Do not widen access width while writing a transmit buffer.
// [R20] Trailing partial word counts only the bytes actually written.
module ufp_host #(
    parameter int POLL_MAX = 255
) (
    input wire logic clk, // 50 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [3:0] sw_addr, // Command register address
    input wire logic [31:0] sw_wdata, // Command write data
    input wire logic sw_wr, // Command write strobe
    input wire logic sw_rd, // Command read strobe
    output logic [31:0] sw_rdata, // Read data, one cycle later
    output ufp_pkg::ufp_dev_req_t dev_req, // Device bus request
    input wire logic [31:0] dev_rdata // Device read data, next cycle
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEL = 3'b001,
        ST_POLL = 3'b010,
        ST_WAIT = 3'b011,
        ST_ACT = 3'b100,
        ST_DONE = 3'b101
    } ufp_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_WRITE = 3'b001,
        OP_COMMIT = 3'b010,
        OP_ZLP = 3'b011,
        OP_RDADDR = 3'b100,
        OP_READ = 3'b101
    } ufp_op_t;

    logic rst_s1_q, rst_q;
    ufp_state_t state_q, state_d;
    ufp_op_t op_q;
    logic [15:0] sel_q;
    logic sel_dirty_q;
    logic tx_dir_q;
    logic [31:0] data_q;
    logic [1:0] last_q;
    logic [15:0] addr_q;
    logic [31:0] rd_q;
    logic [15:0] poll_q;
    logic timeout_q;
    logic started_q;
    logic [1:0] mbw_started_q;
    logic [31:0] sw_rdata_q;
    ufp_pkg::ufp_dev_req_t req_q;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    wire busy = (state_q != ST_IDLE);
    wire wr_sel = sw_wr && sw_addr == ufp_pkg::CMD_SEL_OFS && !busy;
    wire wr_data = sw_wr && sw_addr == ufp_pkg::CMD_DATA_OFS && !busy;
    wire wr_ctrl = sw_wr && sw_addr == ufp_pkg::CMD_CTRL_OFS && !busy;
    wire [1:0] sel_mbw = sel_q[ufp_pkg::SEL_MBW_LSB +: 2];
    wire [1:0] new_mbw = sw_wdata[ufp_pkg::SEL_MBW_LSB +: 2];
    // Forbidden code and widening mid-write both refused
    wire mbw_ok = new_mbw != 2'h3 // see [R18]
        && !(started_q && new_mbw > mbw_started_q); // see [R19]
    // Commit refused on a receive pipe
    wire commit_ok = tx_dir_q; // see [R09]
    wire port_ready_flag = dev_rdata[ufp_pkg::CTR_PORT_READY_FLAG_BIT];

    // Byte enables reflect only the bytes really written
    function automatic logic [3:0] be_of(input logic [1:0] port_access_width,
                                         input logic [1:0] last);
        logic [3:0] full;
        full = (port_access_width == ufp_pkg::MBW_8) ? 4'h1 :
               (port_access_width == ufp_pkg::MBW_16) ? 4'h3 : 4'hF;
        case (last)
            2'h1: be_of = full & 4'h1;
            2'h2: be_of = full & 4'h3;
            2'h3: be_of = full & 4'h7;
            default: be_of = full;
        endcase
    endfunction

    wire [3:0] data_be = be_of(sel_mbw, last_q); // see [R20]

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (sel_dirty_q || op_q != OP_NONE)
                    state_d = sel_dirty_q ? ST_SEL : ST_POLL;
            ST_SEL: state_d = ST_POLL;
            ST_POLL: state_d = ST_WAIT;
            // Port-ready gates every FIFO access and every commit
            ST_WAIT:
                if (port_ready_flag) // see [R16] see [R08]
                    state_d = ST_ACT;
                else if (timeout_q)
                    state_d = ST_DONE;
                else
                    state_d = ST_POLL;
            ST_ACT: state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // Command capture
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            sel_q <= 16'h0000;
            sel_dirty_q <= 1'b0;
            tx_dir_q <= 1'b0;
            op_q <= OP_NONE;
            data_q <= 32'h00000000;
            last_q <= 2'h0;
        end
        else
        begin
            if (wr_sel && mbw_ok)
            begin
                // Rewind bit passes straight to the device
                sel_q <= sw_wdata[15:0]; // see [R14] see [R15]
                tx_dir_q <= sw_wdata[16];
                sel_dirty_q <= 1'b1;
            end
            else if (state_q == ST_SEL)
                sel_dirty_q <= 1'b0;
            // Partial count set by a control write, used by one data write
            if (wr_data)
            begin
                data_q <= sw_wdata;
                op_q <= OP_WRITE;
            end
            else if (wr_ctrl)
            begin
                last_q <= sw_wdata[ufp_pkg::CC_LAST_LSB +: 2];
                if (sw_wdata[ufp_pkg::CC_ZLP] && commit_ok)
                    op_q <= OP_ZLP; // see [R04] see [R07]
                else if (sw_wdata[ufp_pkg::CC_COMMIT] && commit_ok)
                    op_q <= OP_COMMIT; // see [R01] see [R03] see [R05]
                else if (sw_wdata[ufp_pkg::CC_RDADDR])
                    op_q <= OP_RDADDR;
                else if (sw_wdata[ufp_pkg::CC_READ])
                    op_q <= OP_READ;
            end
            else if (state_q == ST_DONE)
                op_q <= OP_NONE;
            if (state_q == ST_ACT && op_q == OP_WRITE)
                last_q <= 2'h0; // see [R20]
        end
    end

    // Poll timeout counter
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            poll_q <= 16'h0000;
            timeout_q <= 1'b0;
        end
        else if (state_q == ST_IDLE)
        begin
            poll_q <= 16'h0000;
            // Timeout stays visible until the next command starts
            if (state_d != ST_IDLE)
                timeout_q <= 1'b0;
        end
        else if (state_q == ST_WAIT)
        begin
            poll_q <= poll_q + 16'h0001;
            timeout_q <= poll_q >= 16'(POLL_MAX);
        end
    end

    // Track writes in progress for the width check
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            started_q <= 1'b0;
            mbw_started_q <= 2'h0;
        end
        else if (state_q == ST_ACT)
        begin
            if (op_q == OP_WRITE)
            begin
                started_q <= 1'b1;
                mbw_started_q <= sel_mbw;
            end
            else if (op_q == OP_COMMIT || op_q == OP_ZLP)
                started_q <= 1'b0;
        end
    end

    // Device bus request, decoded combinationally from the state
    always_comb
    begin
        dev_req = '0;
        case (state_q)
            ST_SEL:
            begin
                dev_req.addr = ufp_pkg::DEV_FIFOSEL_OFS;
                dev_req.wdata = {16'h0000, sel_q};
                dev_req.be = 4'h3;
                dev_req.wr = 1'b1;
            end
            ST_POLL:
            begin
                dev_req.addr = ufp_pkg::DEV_FIFOCTR_OFS;
                dev_req.rd = 1'b1;
            end
            ST_ACT:
            begin
                case (op_q)
                    OP_WRITE:
                    begin
                        dev_req.addr = ufp_pkg::DEV_FIFOPORT_OFS;
                        dev_req.wdata = data_q;
                        dev_req.be = data_be; // see [R20]
                        dev_req.wr = 1'b1;
                    end
                    OP_COMMIT, OP_ZLP:
                    begin
                        dev_req.addr = ufp_pkg::DEV_FIFOCTR_OFS;
                        dev_req.wdata[ufp_pkg::CTR_BUFFER_VALID_BIT] = 1'b1;
                        dev_req.wdata[ufp_pkg::CTR_BUFFER_CLEAR_BIT] = op_q == OP_ZLP;
                        dev_req.be = 4'h3;
                        dev_req.wr = 1'b1;
                    end
                    OP_RDADDR:
                    begin
                        dev_req.addr = ufp_pkg::DEV_ADDR_OFS;
                        dev_req.rd = 1'b1;
                    end
                    OP_READ:
                    begin
                        // Full configured width; software trims
                        dev_req.addr = ufp_pkg::DEV_FIFOPORT_OFS; // see [R17]
                        dev_req.be = be_of(sel_mbw, 2'h0);
                        dev_req.rd = 1'b1;
                    end
                    default: dev_req = '0;
                endcase
            end
            default: dev_req = '0;
        endcase
    end

    // Capture device answers one cycle after the read
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            addr_q <= ufp_pkg::ADDR_RESET;
            rd_q <= 32'h00000000;
            req_q <= '0;
        end
        else
        begin
            req_q <= dev_req;
            if (state_q == ST_DONE && req_q.rd
                && req_q.addr == ufp_pkg::DEV_ADDR_OFS)
                // Upper bits masked to zero
                addr_q <= {9'h000, dev_rdata[ufp_pkg::ADDR_W-1:0]}; // see [R10] see [R13]
            if (state_q == ST_DONE && req_q.rd
                && req_q.addr == ufp_pkg::DEV_FIFOPORT_OFS)
                rd_q <= dev_rdata;
        end
    end

    wire [31:0] stat_word = {28'h0000000, timeout_q, started_q,
                             tx_dir_q, busy};
    wire [31:0] rd_mux =
        (sw_addr == ufp_pkg::CMD_SEL_OFS) ? {15'h0000, tx_dir_q, sel_q} :
        (sw_addr == ufp_pkg::CMD_DATA_OFS) ? rd_q :
        (sw_addr == ufp_pkg::CMD_STAT_OFS) ? stat_word :
        (sw_addr == ufp_pkg::CMD_ADDR_OFS) ? {16'h0000, addr_q} :
        32'h00000000;

    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
            sw_rdata_q <= 32'h00000000;
        else
            sw_rdata_q <= sw_rd ? rd_mux : 32'h00000000;
    end
    assign sw_rdata = sw_rdata_q;

    // Commit is only issued after port-ready was seen
    sequence ready_seen;
        state_q == ST_WAIT && port_ready_flag;
    endsequence
    commit_after_ready_a: assert property (@(posedge clk) disable iff (!rst_q)
        (dev_req.wr && dev_req.wdata[ufp_pkg::CTR_BUFFER_VALID_BIT]
         && dev_req.addr == ufp_pkg::DEV_FIFOCTR_OFS)
        |-> $past(state_q == ST_WAIT && port_ready_flag)) // see [R08]
        else $error("commit without port ready");
    fifo_after_ready_a: assert property (@(posedge clk) disable iff (!rst_q)
        ready_seen |=> state_q == ST_ACT) // see [R16]
        else $error("no access after ready");
    no_rx_commit_a: assert property (@(posedge clk) disable iff (!rst_q)
        (dev_req.wr && dev_req.wdata[ufp_pkg::CTR_BUFFER_VALID_BIT]
         && dev_req.addr == ufp_pkg::DEV_FIFOCTR_OFS) |-> tx_dir_q) // see [R09]
        else $error("commit on receive pipe");
    zlp_clear_a: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == ST_ACT && op_q == OP_ZLP)
        |-> dev_req.wdata[ufp_pkg::CTR_BUFFER_CLEAR_BIT]) // see [R07]
        else $error("empty packet without clear");
    addr_upper_a: assert property (@(posedge clk) disable iff (!rst_q)
        addr_q[15:7] == 9'h000) // see [R13]
        else $error("address upper bits set");
    width_code_a: assert property (@(posedge clk) disable iff (!rst_q)
        sel_mbw != 2'h3) // see [R18]
        else $error("forbidden width code");
    partial_be_a: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == ST_ACT && op_q == OP_WRITE && last_q == 2'h1)
        |-> dev_req.be == 4'h1) // see [R20]
        else $error("partial word enables wrong");
    sel_forward_a: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == ST_SEL) |-> dev_req.wdata[15:0] == sel_q ##1
        state_q == ST_POLL) // see [R14]
        else $error("select not forwarded");
endmodule // ufp_host

// ===== common/ufp_pkg.sv
/*
 * Package for the FIFO port host controller: register map of the device
 * outside, the controller's own command registers, and shared types.
 * Assumes a single 50 MHz clock and a device bus with one-cycle access.
 */
package ufp_pkg;
    // Device registers (offsets on the device port, bytes)
    localparam logic [7:0] DEV_FIFOSEL_OFS = 8'h20;
    localparam logic [7:0] DEV_FIFOCTR_OFS = 8'h22;
    localparam logic [7:0] DEV_FIFOPORT_OFS = 8'h14;
    localparam logic [7:0] DEV_ADDR_OFS = 8'h50;
    // Select register fields
    localparam int SEL_REW_BIT = 14;
    localparam int SEL_MBW_LSB = 10;
    localparam int SEL_PIPE_LSB = 0;
    // Control register fields
    localparam int CTR_BUFFER_VALID_BIT = 15;
    localparam int CTR_BUFFER_CLEAR_BIT = 14;
    localparam int CTR_PORT_READY_FLAG_BIT = 13;
    localparam int CTR_LEN_LSB = 0;
    localparam int ADDR_W = 7;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    // Width codes
    localparam logic [1:0] MBW_8 = 2'h0;
    localparam logic [1:0] MBW_16 = 2'h1;
    localparam logic [1:0] MBW_32 = 2'h2;
    // Own command registers (software port)
    localparam logic [3:0] CMD_SEL_OFS = 4'h0;
    localparam logic [3:0] CMD_DATA_OFS = 4'h1;
    localparam logic [3:0] CMD_CTRL_OFS = 4'h2;
    localparam logic [3:0] CMD_STAT_OFS = 4'h3;
    localparam logic [3:0] CMD_ADDR_OFS = 4'h4;
    // Control command bits
    localparam int CC_COMMIT = 0;
    localparam int CC_ZLP = 1;
    localparam int CC_LAST_LSB = 2;
    localparam int CC_RDADDR = 4;
    localparam int CC_READ = 5;
    localparam logic [15:0] POLL_LIMIT = 16'h00FF;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic wr;
        logic rd;
    } ufp_dev_req_t;
endpackage

// ===== testbench/ufp_dev_model.sv
/*
 * Model of the device outside the host controller: FIFO port select,
 * control, data port and read-only function address, one pointer a pipe.
 * Assumes one-cycle strobes and answers reads in the following cycle.
 */
module ufp_dev_model #(
    parameter int MAXP = 16 // Max packet bytes, non-continuous mode
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Power-on reset, active low
    input wire ufp_pkg::ufp_dev_req_t dev_req, // Host request
    output logic [31:0] dev_rdata, // Read data, next cycle
    input wire logic stall, // Holds port-ready low
    input wire logic bus_reset, // USB bus reset
    input wire logic addr_set, // Address assignment completed
    input wire logic [6:0] addr_new // Address given by the host
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sel_q;
    logic [7:0] ptr_q [16];
    logic [6:0] addr_q;
    int commit_cnt;
    int zlp_cnt;
    int last_len;
    logic [3:0] pipe;
    logic [7:0] nbytes;
    logic [7:0] next_ptr;
    logic [31:0] wd;
    assign pipe = sel_q[3:0];
    assign wd = dev_req.wdata;
    assign nbytes = 8'(dev_req.be[0]) + 8'(dev_req.be[1])
        + 8'(dev_req.be[2]) + 8'(dev_req.be[3]);
    assign next_ptr = ptr_q[pipe] + nbytes;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_q <= 16'h0000;
            addr_q <= 7'h00;
            commit_cnt <= 0;
            zlp_cnt <= 0;
            last_len <= 0;
            dev_rdata <= 32'h0000_0000;
            for (int i = 0; i < 16; i++)
                ptr_q[i] <= 8'h00;
        end
        else
        begin
            // Idle bus toggles so stale data never passes for an answer
            dev_rdata <= ~dev_rdata;
            if (bus_reset)
                addr_q <= 7'h00;
            else if (addr_set)
                addr_q <= addr_new;
            if (dev_req.wr && dev_req.addr == ufp_pkg::DEV_FIFOSEL_OFS)
            begin
                sel_q <= wd[15:0];
                if (wd[ufp_pkg::SEL_REW_BIT])
                    ptr_q[wd[3:0]] <= 8'h00;
            end
            if (dev_req.wr && dev_req.addr == ufp_pkg::DEV_FIFOCTR_OFS
                && wd[ufp_pkg::CTR_BUFFER_VALID_BIT])
            begin
                commit_cnt <= commit_cnt + 1;
                ptr_q[pipe] <= 8'h00;
                last_len <= wd[ufp_pkg::CTR_BUFFER_CLEAR_BIT] ? 0 : ptr_q[pipe];
                if (wd[ufp_pkg::CTR_BUFFER_CLEAR_BIT])
                    zlp_cnt <= zlp_cnt + 1;
            end
            if (dev_req.wr && dev_req.addr == ufp_pkg::DEV_FIFOPORT_OFS)
            begin
                ptr_q[pipe] <= (next_ptr >= MAXP) ? 8'h00 : next_ptr;
                if (next_ptr >= MAXP)
                begin
                    commit_cnt <= commit_cnt + 1;
                    last_len <= next_ptr;
                end
            end
            if (dev_req.rd && dev_req.addr == ufp_pkg::DEV_FIFOCTR_OFS)
                dev_rdata <= {18'h0, !stall, 5'h0, ptr_q[pipe]};
            if (dev_req.rd && dev_req.addr == ufp_pkg::DEV_FIFOPORT_OFS)
                dev_rdata <= 32'hBEEF_0000 + {24'h0, ptr_q[pipe]};
            if (dev_req.rd && dev_req.addr == ufp_pkg::DEV_FIFOSEL_OFS)
                dev_rdata <= {16'h0, sel_q};
            if (dev_req.rd && dev_req.addr == ufp_pkg::DEV_ADDR_OFS)
                dev_rdata <= {25'h0, addr_q};
        end
    end
endmodule // ufp_dev_model

// ===== testbench/tb_ufp_host.sv
/*
 * Self-checking bench for the FIFO port host controller against the
 * device model. Assumes the command map of the package and the controller's status bits.
 */
module tb_ufp_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    ufp_pkg::ufp_dev_req_t dev_req;
    logic [31:0] dev_rdata;
    logic stall = 1'b0;
    logic bus_reset = 1'b0;
    logic addr_set = 1'b0;
    logic [6:0] addr_new = 7'h00;
    int errors = 0;
    int cmp_count = 0;
    int ec = 0;
    logic [31:0] v;

    always #10 clk = ~clk;

    ufp_host #(.POLL_MAX(4)) ufp_host_inst (.clk(clk), .rst_n(rst_n),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_req(dev_req),
        .dev_rdata(dev_rdata));
    ufp_dev_model #(.MAXP(16)) ufp_dev_model_inst (.clk(clk),
        .rst_n(rst_n), .dev_req(dev_req), .dev_rdata(dev_rdata),
        .stall(stall), .bus_reset(bus_reset), .addr_set(addr_set),
        .addr_new(addr_new));

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    // Bounded poll of the busy flag; a hang closes the run
    task automatic cmd(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] s;
        wr(a, d);
        for (int i = 0; i < 200; i++)
        begin
            rd(ufp_pkg::CMD_STAT_OFS, s);
            if (s[0] === 1'b0)
                return;
        end
        errors++;
        $display("MISMATCH t=%0t busy got=%h exp=%h", $time, s, 32'h0);
        test_done();
    endtask

    task automatic sel(input logic [3:0] p, input logic [1:0] w,
        input logic pointer_rewind, input logic tx);
        cmd(ufp_pkg::CMD_SEL_OFS, {15'h0, tx, 1'b0, pointer_rewind, 2'h0, w, 6'h0, p});
    endtask

    task automatic pulse_addr(input logic [6:0] a, input logic br);
        @(posedge clk);
        addr_new <= a;
        addr_set <= !br;
        bus_reset <= br;
        @(posedge clk);
        addr_set <= 1'b0;
        bus_reset <= 1'b0;
        cmd(ufp_pkg::CMD_CTRL_OFS, 32'h10);
        rd(ufp_pkg::CMD_ADDR_OFS, v);
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ufp_pkg::CMD_ADDR_OFS, v);
        chk(v, 32'h0);
        pulse_addr(7'h5A, 1'b0);
        chk(v, 32'h5A);
        pulse_addr(7'h33, 1'b1);
        chk(v, 32'h0);
        // Narrowing order only, since widening mid-buffer is refused
        for (int w = 2; w >= 0; w--)
        begin
            sel(4'h1, 2'(w), 1'b1, 1'b1);
            chk(ufp_dev_model_inst.ptr_q[1], 32'h0);
            cmd(ufp_pkg::CMD_DATA_OFS, 32'hA5A5_A5A5);
            chk(ufp_dev_model_inst.ptr_q[1], 32'(1 << w));
            chk(ufp_dev_model_inst.sel_q[11:10], 32'(w));
        end
        sel(4'h1, ufp_pkg::MBW_32, 1'b0, 1'b1);
        chk(ufp_dev_model_inst.sel_q[11:10], 32'h0);
        cmd(ufp_pkg::CMD_DATA_OFS, 32'h0000_00C3);
        cmd(ufp_pkg::CMD_CTRL_OFS, 32'h1);
        ec++;
        chk(ufp_dev_model_inst.commit_cnt, ec);
        chk(ufp_dev_model_inst.last_len, 32'h2);
        sel(4'h1, 2'h3, 1'b1, 1'b1);
        chk(ufp_dev_model_inst.sel_q[11:10], 32'h0);
        sel(4'h1, ufp_pkg::MBW_32, 1'b1, 1'b1);
        cmd(ufp_pkg::CMD_DATA_OFS, 32'h1111_1111);
        sel(4'h2, ufp_pkg::MBW_32, 1'b1, 1'b1);
        cmd(ufp_pkg::CMD_DATA_OFS, 32'h2222_2222);
        sel(4'h1, ufp_pkg::MBW_32, 1'b0, 1'b1);
        cmd(ufp_pkg::CMD_DATA_OFS, 32'h3333_3333);
        chk(ufp_dev_model_inst.ptr_q[1], 32'h8);
        chk(ufp_dev_model_inst.ptr_q[2], 32'h4);
        cmd(ufp_pkg::CMD_CTRL_OFS, 32'h2);
        ec++;
        chk(ufp_dev_model_inst.zlp_cnt, 32'h1);
        chk(ufp_dev_model_inst.last_len, 32'h0);
        cmd(ufp_pkg::CMD_CTRL_OFS, 32'h1);
        ec++;
        chk(ufp_dev_model_inst.last_len, 32'h0);
        for (int i = 0; i < 4; i++)
            cmd(ufp_pkg::CMD_DATA_OFS, 32'hF0F0_0000 + 32'(i));
        ec++;
        chk(ufp_dev_model_inst.commit_cnt, ec);
        chk(ufp_dev_model_inst.last_len, 32'h10);
        sel(4'h3, ufp_pkg::MBW_32, 1'b1, 1'b0);
        cmd(ufp_pkg::CMD_CTRL_OFS, 32'h1);
        chk(ufp_dev_model_inst.commit_cnt, ec);
        sel(4'h1, ufp_pkg::MBW_32, 1'b1, 1'b1);
        cmd(ufp_pkg::CMD_CTRL_OFS, 32'h4);
        cmd(ufp_pkg::CMD_DATA_OFS, 32'h0000_0077);
        chk(ufp_dev_model_inst.ptr_q[1], 32'h1);
        cmd(ufp_pkg::CMD_DATA_OFS, 32'h0000_0088);
        chk(ufp_dev_model_inst.ptr_q[1], 32'h5);
        cmd(ufp_pkg::CMD_CTRL_OFS, 32'h20);
        rd(ufp_pkg::CMD_DATA_OFS, v);
        chk(v, 32'hBEEF_0005);
        rd(ufp_pkg::CMD_SEL_OFS, v);
        chk(v, 32'h0001_4801);
        // Slow port-ready: the write must wait, then land; held low past the limit, it times out
        sel(4'h1, ufp_pkg::MBW_32, 1'b1, 1'b1);
        stall <= 1'b1;
        wr(ufp_pkg::CMD_DATA_OFS, 32'h4444_4444);
        repeat (3) @(posedge clk);
        stall <= 1'b0;
        cmd(ufp_pkg::CMD_STAT_OFS, 32'h0);
        chk(ufp_dev_model_inst.ptr_q[1], 32'h4);
        stall <= 1'b1;
        cmd(ufp_pkg::CMD_DATA_OFS, 32'h5555_5555);
        rd(ufp_pkg::CMD_STAT_OFS, v);
        chk(v[3], 32'h1);
        chk(ufp_dev_model_inst.ptr_q[1], 32'h4);
        stall <= 1'b0;
        test_done();
    end
endmodule // tb_ufp_host
